// ### design/lcbe_core.sv
// Ladder compare contacts and bit-of-word set/clear evaluator
`timescale 1ns/10ps
`default_nettype none

module lcbe_core
  import lcbe_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                 clk_sys_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 ce_i,
  // Instruction request from the sequencer
  input  wire logic                 start_i,
  input  wire logic [3:0]           op_i,
  input  wire logic [1:0]           src_a_i,
  input  wire logic [AW-1:0]        a_ref_i,
  input  wire logic [1:0]           src_b_i,
  input  wire logic [DW-1:0]        b_ref_i,
  input  wire logic [BIT_IDX_W-1:0] bit_idx_i,
  // Rung accumulator preset
  input  wire logic                 rung_ld_i,
  input  wire logic                 rung_i,
  // Answer
  output logic                      busy_o,
  output logic                      done_o,
  output logic                      illegal_o,
  output logic                      rung_o,
  // Data memory port
  output logic [AW-1:0]             mem_addr_o,
  output logic                      mem_rd_o,
  output logic                      mem_we_o,
  output logic [DW-1:0]             mem_wdata_o,
  input  wire logic [DW-1:0]        mem_rdata_i
);

  lcbe_regs_t    s_q;
  lcbe_regs_t    s_d;
  lcbe_op_t      req_op;
  lcbe_srca_t    req_src_a;
  lcbe_srcb_t    req_src_b;
  lcbe_comb_t    req_comb;
  lcbe_comb_t    cur_comb;
  lcbe_cmp_t     cur_cmp;
  logic          req_bad;
  logic [AW-1:0] req_addr_a;
  logic [DW-1:0] bit_mask;
  logic          contact;

  assign req_op    = lcbe_op_t'(op_i);
  assign req_src_a = lcbe_srca_t'(src_a_i);
  assign req_src_b = lcbe_srcb_t'(src_b_i);
  assign req_comb  = lcbe_comb_of(req_op);
  assign cur_comb  = lcbe_comb_of(s_q.op);
  assign cur_cmp   = lcbe_cmp_of(s_q.op);
  assign bit_mask  = BIT0_MASK << s_q.bit_idx;
  assign contact   = lcbe_contact(cur_cmp, s_q.opa, s_q.opb);

  // Timers and counters only feed compares; bit ops take a word or pointer
  always_comb begin
    req_bad = 1'b0;
    if (op_i > OP_LAST) begin
      req_bad = 1'b1;
    end else if (req_comb == CMB_BIT) begin
      req_bad = (req_src_a == SRC_A_TIMER) || (req_src_a == SRC_A_COUNTER_OPERAND);
    end else begin
      req_bad = (req_src_b == SRC_B_INVALID);
    end
  end

  // Operand A word address; timer and counter numbers index their value tables
  always_comb begin
    case (req_src_a)
      SRC_A_TIMER:           req_addr_a = TMR_VAL_BASE + {{(AW-TC_IDX_W){1'b0}}, a_ref_i[TC_IDX_W-1:0]};
      SRC_A_COUNTER_OPERAND: req_addr_a = CNT_VAL_BASE + {{(AW-TC_IDX_W){1'b0}}, a_ref_i[TC_IDX_W-1:0]};
      default:               req_addr_a = a_ref_i;
    endcase
  end

  always_comb begin
    s_d         = s_q;
    s_d.rd      = 1'b0;
    s_d.we      = 1'b0;
    s_d.done    = 1'b0;
    s_d.illegal = 1'b0;
    case (s_q.state)
      ST_IDLE: begin
        if (rung_ld_i) begin
          s_d.rung = rung_i;
        end
        if (start_i) begin
          s_d.op       = req_op;
          s_d.src_a    = req_src_a;
          s_d.src_b    = req_src_b;
          s_d.b_ref    = b_ref_i;
          s_d.bit_idx  = bit_idx_i;
          s_d.ptr_done = 1'b0;
          if (req_bad) begin
            // Refused in one cycle; memory and accumulator untouched
            s_d.done    = 1'b1;
            s_d.illegal = 1'b1;
          end else begin
            s_d.addr  = req_addr_a;
            s_d.rd    = 1'b1;
            s_d.state = ST_RD_A;
          end
        end
      end
      ST_RD_A: begin
        s_d.state = ST_CAP_A;
      end
      ST_CAP_A: begin
        if ((s_q.src_a == SRC_A_POINTER) && !s_q.ptr_done) begin
          // Pointer word read first, then the word it names
          s_d.addr     = mem_rdata_i;
          s_d.rd       = 1'b1;
          s_d.ptr_done = 1'b1;
          s_d.state    = ST_RD_A;
        end else begin
          s_d.opa      = mem_rdata_i;
          s_d.ptr_done = 1'b0;
          if (cur_comb == CMB_BIT) begin
            // Address stays on the resolved word for the write back
            s_d.state = ST_EXEC;
          end else if (s_q.src_b == SRC_B_CONST) begin
            s_d.opb   = s_q.b_ref;
            s_d.state = ST_EXEC;
          end else begin
            s_d.addr  = s_q.b_ref;
            s_d.rd    = 1'b1;
            s_d.state = ST_RD_B;
          end
        end
      end
      ST_RD_B: begin
        s_d.state = ST_CAP_B;
      end
      ST_CAP_B: begin
        if ((s_q.src_b == SRC_B_POINTER) && !s_q.ptr_done) begin
          s_d.addr     = mem_rdata_i;
          s_d.rd       = 1'b1;
          s_d.ptr_done = 1'b1;
          s_d.state    = ST_RD_B;
        end else begin
          s_d.opb   = mem_rdata_i;
          s_d.state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        s_d.done  = 1'b1;
        s_d.state = ST_IDLE;
        case (cur_comb)
          CMB_BIT: begin
            // No write while the rung is false, so the bit keeps its last forced value
            if (s_q.rung) begin
              s_d.we = 1'b1;
              if (s_q.op == OP_SET_BIT_OF_WORD) begin
                s_d.wdata = s_q.opa | bit_mask;
              end else begin
                s_d.wdata = s_q.opa & ~bit_mask;
              end
            end
          end
          CMB_START: begin
            s_d.rung = contact;
          end
          CMB_PARALLEL: begin
            s_d.rung = s_q.rung | contact;
          end
          default: begin
            s_d.rung = s_q.rung & contact;
          end
        endcase
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= REGS_RST;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign busy_o      = (s_q.state != ST_IDLE);
  assign done_o      = s_q.done;
  assign illegal_o   = s_q.illegal;
  assign rung_o      = s_q.rung;
  assign mem_addr_o  = s_q.addr;
  assign mem_rd_o    = s_q.rd;
  assign mem_we_o    = s_q.we;
  assign mem_wdata_o = s_q.wdata;

  // Helpers read only by the checks below
  logic          in_exec;
  logic [DW-1:0] opa_w;
  assign in_exec = (s_q.state == ST_EXEC) && ce_i;
  assign opa_w   = s_q.opa;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  a_set_bit_one: assert property (
    (in_exec && s_q.op == OP_SET_BIT_OF_WORD && s_q.rung)
      |=> mem_we_o && (mem_wdata_o == ($past(opa_w) | $past(bit_mask))))
    else $error("set-bit did not write the word with only the addressed bit forced high");

  a_clr_bit_zero: assert property (
    (in_exec && s_q.op == OP_CLEAR_BIT_OF_WORD && s_q.rung)
      |=> mem_we_o && (mem_wdata_o == ($past(opa_w) & ~$past(bit_mask))))
    else $error("clear-bit did not write the word with only the addressed bit forced low");

  a_write_needs_rung: assert property (
    // A frozen cycle keeps the strobe up, so only its first enabled cycle is traced back
    (mem_we_o && $past(ce_i)) |-> $past(s_q.state) == ST_EXEC && $past(rung_o) && (cur_comb == CMB_BIT))
    else $error("data word written without a true rung at a bit operation");

  a_start_replace: assert property (
    (in_exec && cur_comb == CMB_START) |=> rung_o == $past(contact) && done_o)
    else $error("starting contact did not replace the accumulator");

  a_parallel_or: assert property (
    (in_exec && cur_comb == CMB_PARALLEL) |=> rung_o == ($past(rung_o) | $past(contact)))
    else $error("parallel contact not ORed into the accumulator");

  a_series_and: assert property (
    (in_exec && cur_comb == CMB_SERIES) |=> rung_o == ($past(rung_o) & $past(contact)))
    else $error("series contact not ANDed with the accumulator");

  a_unsigned_ge: assert property (
    (s_q.state == ST_EXEC && cur_cmp == CMP_GE && s_q.opa[DW-1] && !s_q.opb[DW-1]) |-> contact)
    else $error("at-least compare treated the operands as signed");

  a_ptr_resolve: assert property (
    (s_q.state == ST_CAP_A && s_q.src_a == SRC_A_POINTER && !s_q.ptr_done && ce_i)
      |=> mem_rd_o && mem_addr_o == $past(mem_rdata_i))
    else $error("pointer operand not followed to the word it names");

  a_step_bound: assert property (
    (s_q.state == ST_IDLE && start_i && ce_i) |-> ##[1:10] (done_o || !ce_i))
    else $error("instruction step did not finish in time");

  a_done_pulse: assert property (
    // A refused request given back to back legally ends at once with a fresh pulse
    (done_o && ce_i) |=> !done_o || (illegal_o && $past(start_i)))
    else $error("done held longer than one cycle");

  c_set_bit: cover property (in_exec && s_q.op == OP_SET_BIT_OF_WORD && s_q.rung);
  c_ptr_cmp: cover property (in_exec && s_q.src_a == SRC_A_POINTER && cur_comb == CMB_SERIES);
  c_par_less: cover property (in_exec && cur_cmp == CMP_LT && cur_comb == CMB_PARALLEL && contact);
  c_refused: cover property (illegal_o);

endmodule : lcbe_core

`default_nettype wire

// ### design/lcbe_pkg.sv
// Constants, types and helpers for the ladder compare and bit-of-word evaluator
// Contract
// - Set-bit with true rung forces the addressed word bit to one, others unchanged.
// - A set bit stays one after the rung falls, until a clear-bit addresses it.
// - Clear-bit with true rung forces the addressed word bit to zero, others unchanged.
// - A cleared bit stays zero after the rung falls; rung need not persist.
// - Bit index runs 0 to 15; word given directly or through a pointer.
// - Start-if-equal starts a rung with contact true when A equals B.
// - Start-if-not-equal starts a rung with contact true when A differs from B.
// - Parallel-if-equal ORs into the rung a contact true when A equals B.
// - Parallel-if-not-equal ORs into the rung a contact true when A differs from B.
// - Series-if-equal ANDs with the rung a contact true when A equals B.
// - Series-if-not-equal ANDs with the rung a contact true when A differs from B.
// - Start-if-at-least starts a rung, true when A >= B; A may be timer/counter.
// - Start-if-less starts a rung with contact true when A is less than B.
// - Parallel-if-at-least ORs into the rung a contact true when A >= B.
// - Parallel-if-less ORs into the rung a contact true when A < B.
// - Series-if-at-least ANDs with the rung a contact true when A >= B.
// - Series-if-less ANDs with the rung a contact true when A < B.
package lcbe_pkg;

  localparam int unsigned DW        = 16;
  localparam int unsigned AW        = 16;
  localparam int unsigned BIT_IDX_W = 4;
  localparam int unsigned TC_IDX_W  = 8;

  // Timer and counter current values live in data memory at these word bases
  localparam logic [AW-1:0] TMR_VAL_BASE = 16'h0200;
  localparam logic [AW-1:0] CNT_VAL_BASE = 16'h0300;
  localparam logic [DW-1:0] BIT0_MASK    = 16'h0001;

  typedef enum logic [3:0] {
    OP_SET_BIT_OF_WORD        = 4'h0,
    OP_CLEAR_BIT_OF_WORD      = 4'h1,
    OP_START_IF_EQUAL         = 4'h2,
    OP_START_IF_NOT_EQUAL     = 4'h3,
    OP_PARALLEL_IF_EQUAL      = 4'h4,
    OP_PARALLEL_IF_NOT_EQUAL  = 4'h5,
    OP_SERIES_IF_EQUAL        = 4'h6,
    OP_SERIES_IF_NOT_EQUAL    = 4'h7,
    OP_START_IF_AT_LEAST      = 4'h8,
    OP_START_IF_LESS          = 4'h9,
    OP_PARALLEL_IF_AT_LEAST   = 4'ha,
    OP_PARALLEL_IF_LESS       = 4'hb,
    OP_SERIES_IF_AT_LEAST     = 4'hc,
    OP_SERIES_IF_LESS         = 4'hd
  } lcbe_op_t;

  localparam logic [3:0] OP_LAST = 4'hd;

  typedef enum logic [1:0] {
    SRC_A_WORD             = 2'h0,
    SRC_A_POINTER          = 2'h1,
    SRC_A_TIMER            = 2'h2,
    SRC_A_COUNTER_OPERAND  = 2'h3
  } lcbe_srca_t;

  typedef enum logic [1:0] {
    SRC_B_WORD     = 2'h0,
    SRC_B_POINTER  = 2'h1,
    SRC_B_CONST    = 2'h2,
    SRC_B_INVALID  = 2'h3
  } lcbe_srcb_t;

  typedef enum logic [1:0] {
    CMB_START     = 2'h0,
    CMB_PARALLEL  = 2'h1,
    CMB_SERIES    = 2'h2,
    CMB_BIT       = 2'h3
  } lcbe_comb_t;

  typedef enum logic [1:0] {
    CMP_EQ = 2'h0,
    CMP_NE = 2'h1,
    CMP_GE = 2'h2,
    CMP_LT = 2'h3
  } lcbe_cmp_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RD_A  = 3'h1,
    ST_CAP_A = 3'h3,
    ST_RD_B  = 3'h2,
    ST_CAP_B = 3'h6,
    ST_EXEC  = 3'h7
  } lcbe_state_t;

  typedef struct packed {
    lcbe_state_t          state;
    lcbe_op_t             op;
    lcbe_srca_t           src_a;
    lcbe_srcb_t           src_b;
    logic [DW-1:0]        b_ref;
    logic [BIT_IDX_W-1:0] bit_idx;
    logic                 ptr_done;
    logic [DW-1:0]        opa;
    logic [DW-1:0]        opb;
    logic [AW-1:0]        addr;
    logic                 rd;
    logic                 we;
    logic [DW-1:0]        wdata;
    logic                 rung;
    logic                 done;
    logic                 illegal;
  } lcbe_regs_t;

  localparam lcbe_regs_t REGS_RST = '0;

  function automatic lcbe_comb_t lcbe_comb_of(input lcbe_op_t op);
    case (op)
      OP_SET_BIT_OF_WORD, OP_CLEAR_BIT_OF_WORD: lcbe_comb_of = CMB_BIT;
      OP_START_IF_EQUAL, OP_START_IF_NOT_EQUAL,
      OP_START_IF_AT_LEAST, OP_START_IF_LESS: lcbe_comb_of = CMB_START;
      OP_PARALLEL_IF_EQUAL, OP_PARALLEL_IF_NOT_EQUAL,
      OP_PARALLEL_IF_AT_LEAST, OP_PARALLEL_IF_LESS: lcbe_comb_of = CMB_PARALLEL;
      default: lcbe_comb_of = CMB_SERIES;
    endcase
  endfunction : lcbe_comb_of

  function automatic lcbe_cmp_t lcbe_cmp_of(input lcbe_op_t op);
    case (op)
      OP_START_IF_EQUAL, OP_PARALLEL_IF_EQUAL, OP_SERIES_IF_EQUAL: lcbe_cmp_of = CMP_EQ;
      OP_START_IF_NOT_EQUAL, OP_PARALLEL_IF_NOT_EQUAL,
      OP_SERIES_IF_NOT_EQUAL: lcbe_cmp_of = CMP_NE;
      OP_START_IF_LESS, OP_PARALLEL_IF_LESS, OP_SERIES_IF_LESS: lcbe_cmp_of = CMP_LT;
      default: lcbe_cmp_of = CMP_GE;
    endcase
  endfunction : lcbe_cmp_of

  // Operands are plain unsigned patterns
  function automatic logic lcbe_contact(input lcbe_cmp_t cmp, input logic [DW-1:0] a,
                                        input logic [DW-1:0] b);
    case (cmp)
      CMP_EQ:  lcbe_contact = (a == b);
      CMP_NE:  lcbe_contact = (a != b);
      CMP_GE:  lcbe_contact = (a >= b);
      default: lcbe_contact = (a < b);
    endcase
  endfunction : lcbe_contact

endpackage : lcbe_pkg

// ### sim/lcbe_core_tb.sv
// Self-checking bench for the compare contact and bit-of-word evaluator
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end

module lcbe_core_tb;
  import lcbe_pkg::*;

  logic                 clk_sys_i, arst_n_i, ce_i, start_i, rung_ld_i, rung_i;
  logic [3:0]           op_i;
  logic [1:0]           src_a_i, src_b_i;
  logic [AW-1:0]        a_ref_i, mem_addr_o;
  logic [DW-1:0]        b_ref_i, mem_wdata_o;
  logic [DW-1:0]        mem_rdata_i = '0;
  logic [BIT_IDX_W-1:0] bit_idx_i;
  logic                 busy_o, done_o, illegal_o, rung_o, mem_rd_o, mem_we_o;
  logic [DW-1:0]        mem [0:1023];
  int                   err_count, checked;
  logic                 exp_rung;

  lcbe_core uut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .start_i(start_i), .op_i(op_i),
    .src_a_i(src_a_i), .a_ref_i(a_ref_i), .src_b_i(src_b_i), .b_ref_i(b_ref_i), .bit_idx_i(bit_idx_i),
    .rung_ld_i(rung_ld_i), .rung_i(rung_i), .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o),
    .rung_o(rung_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_we_o(mem_we_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // Read data is valid only in the cycle after the strobe; otherwise it toggles so stale data is caught
  // It holds while the enable is low, as the frozen block still waits to capture it
  always @(posedge clk_sys_i) begin
    if (ce_i) mem_rdata_i <= mem_rd_o ? mem[mem_addr_o[9:0]] : ~mem_rdata_i;
    if (mem_we_o === 1'b1) mem[mem_addr_o[9:0]] <= mem_wdata_o;
  end

  function automatic logic [DW-1:0] opnd_a(input logic [1:0] sa, input logic [AW-1:0] r);
    case (sa)
      2'h0: return mem[r[9:0]];
      2'h1: return mem[mem[r[9:0]][9:0]];
      2'h2: return mem[TMR_VAL_BASE[9:0] + {2'h0, r[7:0]}];
      default: return mem[CNT_VAL_BASE[9:0] + {2'h0, r[7:0]}];
    endcase
  endfunction : opnd_a

  function automatic logic [DW-1:0] opnd_b(input logic [1:0] sb, input logic [DW-1:0] r);
    case (sb)
      2'h0: return mem[r[9:0]];
      2'h1: return mem[mem[r[9:0]][9:0]];
      default: return r;
    endcase
  endfunction : opnd_b

  // Unsigned comparison, independent of any design helper
  function automatic logic contact(input logic [3:0] op, input logic [DW-1:0] a, input logic [DW-1:0] b);
    case (op)
      4'h2, 4'h4, 4'h6: return a == b;
      4'h3, 4'h5, 4'h7: return a != b;
      4'h8, 4'ha, 4'hc: return a >= b;
      default: return a < b;
    endcase
  endfunction : contact

  function automatic logic [DW-1:0] rnd_val();
    int r;
    r = $urandom_range(5);
    return r == 4 ? 16'hffff : r == 5 ? 16'($urandom) : 16'(r);
  endfunction : rnd_val

  task automatic results();
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic preset(input logic v);
    rung_ld_i = 1'b1;
    rung_i    = v;
    ce_i      = 1'b1;
    @(negedge clk_sys_i);
    rung_ld_i = 1'b0;
    exp_rung  = v;
    `CHK(rung_o, v)
  endtask : preset

  // Called at a falling edge with the block idle; returns at the falling edge that shows done
  task automatic run_op(input logic [3:0] op, input logic [1:0] sa, input logic [AW-1:0] ar,
                        input logic [1:0] sb, input logic [DW-1:0] br, input logic [3:0] bi);
    logic [DW-1:0] a, b, w;
    logic [9:0]    wa;
    logic          ill, bop, c, er, ew;
    int            lat, seen, lp;
    ce_i = 1'b1;
    start_i = 1'b1;
    op_i = op;
    src_a_i = sa;
    a_ref_i = ar;
    src_b_i = sb;
    b_ref_i = br;
    bit_idx_i = bi;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    start_i = 1'b0;
    bop = op < 4'h2;
    ill = op > 4'hd || (bop && sa[1]) || (!bop && sb == 2'h3);
    a = opnd_a(sa, ar);
    b = opnd_b(sb, br);
    c = contact(op, a, b);
    wa = sa[0] ? mem[ar[9:0]][9:0] : ar[9:0];
    w = op[0] ? mem[wa] & ~(16'h0001 << bi) : mem[wa] | (16'h0001 << bi);
    lat = ill ? 0 : 3 + (sa == 2'h1 ? 2 : 0) + (bop ? 0 : sb == 2'h0 ? 2 : sb == 2'h1 ? 4 : 0);
    er = exp_rung;
    if (!ill && !bop) begin
      er = op inside {4'h2, 4'h3, 4'h8, 4'h9} ? c : op inside {4'h4, 4'h5, 4'ha, 4'hb} ? exp_rung | c : exp_rung & c;
    end
    ew = bop && !ill && exp_rung;
    seen = 0;
    lp = 0;
    while (done_o !== 1'b1) begin
      ce_i = ($urandom_range(3) != 0);
      @(negedge clk_sys_i);
      seen += int'(ce_i);
      if (done_o !== 1'b1) `CHK(mem_we_o, 1'b0)
      if (done_o !== 1'b1) `CHK(busy_o, 1'b1)
      if (++lp > 100) begin
        err_count++;
        results();
      end
    end
    `CHK(seen, lat)
    `CHK(busy_o, 1'b0)
    `CHK(illegal_o, ill)
    `CHK(rung_o, er)
    `CHK(mem_we_o, ew)
    if (ew) begin
      `CHK(mem_addr_o, {6'h00, wa})
      `CHK(mem_wdata_o, w)
    end
    exp_rung = er;
  endtask : run_op

  initial begin
    #(20 * 60000);
    err_count++;
    results();
  end

  initial begin
    logic [1:0] sa, sb;
    logic [AW-1:0] ar;
    err_count = 0;
    checked = 0;
    exp_rung = 1'b0;
    {ce_i, start_i, rung_ld_i, rung_i, op_i, src_a_i, src_b_i, a_ref_i, b_ref_i, bit_idx_i} = '0;
    arst_n_i = 1'b0;
    void'($urandom(32'hbc9fb036));
    for (int i = 0; i < 1024; i++) begin
      mem[i] = (i >= 16'h40 && i < 16'h50) ? 16'($urandom_range(63)) : rnd_val();
    end
    mem[16'h11] = 16'hffff;
    mem[16'h12] = 16'h0000;
    repeat (20) @(posedge clk_sys_i);
    `CHK(rung_o, 1'b0)
    `CHK(busy_o, 1'b0)
    @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    // Directed corners: bit 15 and bit 0, false rung leaves word alone, unsigned extremes
    preset(1'b1);
    run_op(4'h0, 2'h0, 16'h0010, 2'h0, 16'h0000, 4'hf);
    preset(1'b0);
    run_op(4'h1, 2'h0, 16'h0010, 2'h0, 16'h0000, 4'hf);
    `CHK(mem[16'h10][15], 1'b1)
    preset(1'b1);
    run_op(4'h1, 2'h1, 16'h0040, 2'h0, 16'h0000, 4'h0);
    run_op(4'h8, 2'h0, 16'h0011, 2'h2, 16'h0000, 4'h0);
    run_op(4'hb, 2'h0, 16'h0012, 2'h2, 16'hffff, 4'h0);
    run_op(4'hd, 2'h0, 16'h0011, 2'h0, 16'h0012, 4'h0);
    run_op(4'h2, 2'h0, 16'h0011, 2'h2, 16'hffff, 4'h0);
    run_op(4'he, 2'h0, 16'h0011, 2'h0, 16'h0012, 4'h0);
    for (int i = 0; i < 600; i++) begin
      if ($urandom_range(3) == 0) preset(1'($urandom_range(1)));
      sa = 2'($urandom_range(3));
      ar = sa == 2'h1 ? 16'h0040 + 16'($urandom_range(15)) : sa[1] ? 16'($urandom) : 16'($urandom_range(63));
      sb = $urandom_range(7) == 0 ? 2'h3 : 2'($urandom_range(2));
      run_op(4'($urandom_range(15)), sa, ar, sb,
             sb == 2'h2 ? rnd_val() : sb == 2'h1 ? 16'h0040 + 16'($urandom_range(15)) : 16'($urandom_range(63)),
             4'($urandom_range(15)));
    end
    results();
  end

endmodule : lcbe_core_tb

`default_nettype wire
